// ### hw/irc_pkg.sv
// Constants and types of the input range configuration register bank
// Functional notes
// RL1: Frame bit 15 set requests a write, clear requests a read.
// RL2: Frame bits 14..9 name the register that the access targets.
// RL3: Bit 8 of every range register always reads back as zero.
// RL4: Codes 00 and 11 mean 10 V, 01 means 2.5 V, 10 means 5 V.
// RL5: Register 4 holds group A channels 3..0 in pairs 7-6 down to 1-0.
// RL6: Register 5 holds group A channels 7..4 in the same pair layout.
// RL7: Register 5 resets to 0xaff, all four codes at 11.
// RL8: Register 4 resets to 0x8ff, all four codes at 11.
// RL9: Register 6 holds group B channels 3..0, resets to 0xcff.
// RL10: Address field reads back as the register's own address.
// RL11: Writes change only the eight code bits of the addressed register.
package irc_pkg;

  // Word indexes; byte address is the index times four
  localparam int unsigned ADR_LSB = 2;
  localparam logic [5:0] IDX_CMD = 6'h00;
  localparam logic [5:0] IDX_RSP = 6'h01;
  localparam logic [5:0] IDX_RNG_A_LO = 6'h04;
  localparam logic [5:0] IDX_RNG_A_HI = 6'h05;
  localparam logic [5:0] IDX_RNG_B_LO = 6'h06;
  localparam logic [5:0] IDX_RNG_FIRST = IDX_RNG_A_LO;
  localparam logic [5:0] IDX_RNG_LAST = IDX_RNG_B_LO;
  localparam int unsigned NUM_RNG = 3;

  // Frame layout
  localparam int unsigned FRM_DIR_BIT = 15;
  localparam int unsigned FRM_ADR_HI = 14;
  localparam int unsigned FRM_ADR_LO = 9;
  localparam int unsigned FRM_RSV_BIT = 8;
  localparam int unsigned FRM_CODE_HI = 7;

  // Reset words
  localparam logic [15:0] RST_A_LO = 16'h08ff;
  localparam logic [15:0] RST_A_HI = 16'h0aff;
  localparam logic [15:0] RST_B_LO = 16'h0cff;
  localparam logic [NUM_RNG-1:0][15:0] RNG_RST =
    {RST_B_LO, RST_A_HI, RST_A_LO};

  // Range codes
  localparam logic [1:0] CODE_10V_A = 2'h0;
  localparam logic [1:0] CODE_2P5V = 2'h1;
  localparam logic [1:0] CODE_5V = 2'h2;
  localparam logic [1:0] CODE_10V_B = 2'h3;

  localparam logic [1:0] SEL_BOTH = 2'h3;
  localparam logic [31:0] DAT_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    IRC_RNG_10V,
    IRC_RNG_5V,
    IRC_RNG_2P5V
  } irc_range_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } irc_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } irc_wb_rsp_t;

  // Readback word of a range register
  function automatic logic [15:0] irc_frame(input logic [5:0] idx,
                                            input logic [7:0] codes);
    irc_frame = {1'b0, idx, 1'b0, codes};
  endfunction

  function automatic logic irc_is_rng(input logic [5:0] idx);
    irc_is_rng = (idx >= IDX_RNG_FIRST) && (idx <= IDX_RNG_LAST);
  endfunction

  function automatic logic [1:0] irc_slot(input logic [5:0] idx);
    logic [5:0] off;
    off = idx - IDX_RNG_FIRST;
    irc_slot = off[1:0];
  endfunction

endpackage

// ### hw/irc_range_dec.sv
// Decoder from four packed range codes to range selections
`timescale 1ns/1ps
module irc_range_dec (
  input wire logic [7:0] i_codes,
  output irc_pkg::irc_range_t [3:0] o_range
);

  function automatic irc_pkg::irc_range_t dec(input logic [1:0] code);
    case (code)
      irc_pkg::CODE_2P5V: dec = irc_pkg::IRC_RNG_2P5V;
      irc_pkg::CODE_5V: dec = irc_pkg::IRC_RNG_5V;
      default: dec = irc_pkg::IRC_RNG_10V;
    endcase
  endfunction

  for (genvar i = 0; i < 4; i++) begin : g_ch
    assign o_range[i] = dec(i_codes[2*i+:2]); // [RL4]
  end

endmodule

// ### hw/irc_range_regs.sv
// Range configuration register bank with a classic Wishbone slave
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module irc_range_regs (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire irc_pkg::irc_wb_req_t i_wb,
  output irc_pkg::irc_wb_rsp_t o_wb,
  output logic [7:0][1:0] o_grp_a_range_code,
  output logic [3:0][1:0] o_grp_b_range_code,
  output irc_pkg::irc_range_t [7:0] o_grp_a_range,
  output irc_pkg::irc_range_t [3:0] o_grp_b_range
);

  logic ack_q;
  logic [31:0] rdat_q;
  logic [irc_pkg::NUM_RNG-1:0][7:0] rng_q;
  logic [15:0] cmd_q;
  logic [15:0] rsp_q;
  logic [7:0][1:0] a_code_q;
  logic [3:0][1:0] b_code_q;
  irc_pkg::irc_range_t [7:0] a_rng_q;
  irc_pkg::irc_range_t [3:0] b_rng_q;

  // Bus decode
  wire logic bus_req = i_wb.cyc & i_wb.stb;
  wire logic bus_take = bus_req & ~ack_q;
  wire logic bus_commit = bus_req & ack_q;
  wire logic bus_wr = bus_commit & i_wb.we;
  wire logic [5:0] idx = i_wb.adr[7:irc_pkg::ADR_LSB];
  wire logic idx_rng = irc_pkg::irc_is_rng(idx);
  wire logic [1:0] idx_slot = irc_pkg::irc_slot(idx);
  wire logic idx_cmd = (idx == irc_pkg::IDX_CMD);
  wire logic idx_rsp = (idx == irc_pkg::IDX_RSP);

  // Direct write into a range register, code lane only
  wire logic dir_wr = bus_wr & idx_rng & i_wb.sel[0]; // [RL11]

  // Command frame path
  wire logic [15:0] frm = i_wb.dat[15:0];
  wire logic frm_take = bus_wr & idx_cmd &
    (i_wb.sel[1:0] == irc_pkg::SEL_BOTH);
  wire logic frm_is_wr = frm[irc_pkg::FRM_DIR_BIT]; // [RL1]
  wire logic [5:0] frm_idx =
    frm[irc_pkg::FRM_ADR_HI:irc_pkg::FRM_ADR_LO]; // [RL2]
  wire logic frm_rng = irc_pkg::irc_is_rng(frm_idx);
  wire logic [1:0] frm_slot = irc_pkg::irc_slot(frm_idx);
  wire logic frm_wr = frm_take & frm_is_wr & frm_rng; // [RL1] [RL11]
  wire logic frm_rd = frm_take & ~frm_is_wr; // [RL1]
  wire logic [15:0] frm_rb = frm_rng ?
    irc_pkg::irc_frame(frm_idx, rng_q[frm_slot]) : 16'h0000; // [RL10]

  // Readback of the bus-addressed register
  wire logic [15:0] bus_rb = idx_rng ?
    irc_pkg::irc_frame(idx, rng_q[idx_slot]) : 16'h0000; // [RL3] [RL10]
  wire logic [15:0] rd_word = idx_rng ? bus_rb :
                              idx_cmd ? cmd_q :
                              idx_rsp ? rsp_q : 16'h0000;

  // Channel decode, low register holds the lower channels
  irc_pkg::irc_range_t [3:0] dec_a_lo;
  irc_pkg::irc_range_t [3:0] dec_a_hi;
  irc_pkg::irc_range_t [3:0] dec_b_lo;

  irc_range_dec u_dec_a_lo (
    .i_codes(rng_q[0]),
    .o_range(dec_a_lo)
  );

  irc_range_dec u_dec_a_hi (
    .i_codes(rng_q[1]),
    .o_range(dec_a_hi)
  );

  irc_range_dec u_dec_b_lo (
    .i_codes(rng_q[2]),
    .o_range(dec_b_lo)
  );

  // Bus answer: ack one cycle after the request, dropped next cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_q <= 1'b0;
      rdat_q <= irc_pkg::DAT_ZERO;
    end else begin
      ack_q <= bus_take;
      if (bus_take) begin
        rdat_q <= {16'h0000, rd_word};
      end
    end
  end

  // Range code storage
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < irc_pkg::NUM_RNG; i++) begin
        rng_q[i] <= irc_pkg::RNG_RST[i][irc_pkg::FRM_CODE_HI:0]; // [RL7]
      end
    end else if (dir_wr) begin
      rng_q[idx_slot] <= i_wb.dat[irc_pkg::FRM_CODE_HI:0]; // [RL11]
    end else if (frm_wr) begin
      rng_q[frm_slot] <= frm[irc_pkg::FRM_CODE_HI:0]; // [RL1] [RL2]
    end
  end

  // Command echo and readback response
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmd_q <= 16'h0000;
      rsp_q <= 16'h0000;
    end else begin
      if (frm_take) begin
        cmd_q <= frm;
      end
      if (frm_rd) begin
        rsp_q <= frm_rb; // [RL1] [RL2] [RL3]
      end
    end
  end

  // Registered channel outputs
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      a_code_q <= {irc_pkg::RST_A_HI[7:0], irc_pkg::RST_A_LO[7:0]}; // [RL8]
      b_code_q <= irc_pkg::RST_B_LO[7:0]; // [RL9]
      foreach (a_rng_q[i]) begin
        a_rng_q[i] <= irc_pkg::IRC_RNG_10V;
      end
      foreach (b_rng_q[i]) begin
        b_rng_q[i] <= irc_pkg::IRC_RNG_10V;
      end
    end else begin
      a_code_q <= {rng_q[1], rng_q[0]}; // [RL5] [RL6]
      b_code_q <= rng_q[2]; // [RL9]
      a_rng_q[3:0] <= dec_a_lo; // [RL4] [RL5]
      a_rng_q[7:4] <= dec_a_hi; // [RL4] [RL6]
      b_rng_q <= dec_b_lo; // [RL4]
    end
  end

  assign o_wb.ack = ack_q;
  assign o_wb.dat = rdat_q;
  assign o_grp_a_range_code = a_code_q;
  assign o_grp_b_range_code = b_code_q;
  assign o_grp_a_range = a_rng_q;
  assign o_grp_b_range = b_rng_q;

  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  a_ack_single_pulse: assert property (
    ack_q |=> !ack_q
  ) else $error("ack stood for more than one cycle");

  a_rsv_bit_zero: assert property ( // [RL3]
    ack_q && bus_req && idx_rng |-> o_wb.dat[irc_pkg::FRM_RSV_BIT] == 1'b0
  ) else $error("reserved bit read back as one");

  a_adr_field_own: assert property ( // [RL10]
    ack_q && bus_req && idx_rng |->
      o_wb.dat[irc_pkg::FRM_ADR_HI:irc_pkg::FRM_ADR_LO] == idx
  ) else $error("address field differs from register address");

  a_reset_a_lo: assert property ( // [RL8]
    $rose(i_rst_b) |-> rng_q[0] == irc_pkg::RST_A_LO[7:0]
  ) else $error("low group A register reset value wrong");

  a_reset_a_hi: assert property ( // [RL7]
    $rose(i_rst_b) |-> rng_q[1] == irc_pkg::RST_A_HI[7:0]
  ) else $error("high group A register reset value wrong");

  a_reset_b_lo: assert property ( // [RL9]
    $rose(i_rst_b) |-> rng_q[2] == irc_pkg::RST_B_LO[7:0]
  ) else $error("low group B register reset value wrong");

  a_frame_write_lands: assert property ( // [RL1]
    frm_wr |=> rng_q[$past(frm_slot)] == $past(frm[7:0])
  ) else $error("write frame did not update the target codes");

  a_frame_read_resp: assert property ( // [RL2]
    frm_rd |=> rsp_q == $past(frm_rb) && $stable(rng_q)
  ) else $error("read frame gave a wrong response");

  a_no_stray_write: assert property ( // [RL11]
    !(dir_wr || frm_wr) |=> $stable(rng_q)
  ) else $error("range codes changed without a write");

  a_decode_2p5v: assert property ( // [RL4]
    rng_q[0][1:0] == irc_pkg::CODE_2P5V |=>
      o_grp_a_range[0] == irc_pkg::IRC_RNG_2P5V
  ) else $error("code 01 not decoded as 2.5 V");

  a_decode_10v: assert property ( // [RL4]
    rng_q[2][7:6] == irc_pkg::CODE_10V_A |=>
      o_grp_b_range[3] == irc_pkg::IRC_RNG_10V
  ) else $error("code 00 not decoded as 10 V");

  a_layout_a_lo: assert property ( // [RL5]
    1'b1 |=> o_grp_a_range_code[3] == $past(rng_q[0][7:6])
  ) else $error("group A channel 3 not at bits 7-6 of register 4");

  a_layout_a_hi: assert property ( // [RL6]
    1'b1 |=> o_grp_a_range_code[4] == $past(rng_q[1][1:0])
  ) else $error("group A channel 4 not at bits 1-0 of register 5");

  a_ack_after_take: assert property (
    bus_take |=>
      ack_q
  ) else $error("request taken without an ack");

  a_ack_needs_take: assert property (
    ack_q |->
      $past(bus_take)
  ) else $error("ack without a taken request");

  a_rdat_stands: assert property (
    ack_q |=>
      $stable(o_wb.dat)
  ) else $error("read data changed right after ack");

  a_rdat_upper_zero: assert property (
    ack_q |->
      o_wb.dat[31:16] == 16'h0000
  ) else $error("upper read data bits not zero");

  a_dir_bit_zero: assert property ( // [RL1]
    ack_q && bus_req && idx_rng |->
      o_wb.dat[irc_pkg::FRM_DIR_BIT] == 1'b0
  ) else $error("direction bit read back as one");

  a_unmapped_zero: assert property (
    ack_q && bus_req && !idx_rng && !idx_cmd && !idx_rsp |->
      o_wb.dat == irc_pkg::DAT_ZERO
  ) else $error("unmapped read returned data");

  a_direct_lands: assert property ( // [RL11]
    dir_wr |=>
      rng_q[$past(idx_slot)] == $past(i_wb.dat[irc_pkg::FRM_CODE_HI:0])
  ) else $error("direct write did not update the codes");

  a_sel_guard: assert property ( // [RL11]
    bus_wr && idx_rng && !i_wb.sel[0] |=>
      $stable(rng_q)
  ) else $error("write with code lane off changed the codes");

  a_cmd_sel_guard: assert property ( // [RL11]
    bus_wr && idx_cmd && i_wb.sel[1:0] != irc_pkg::SEL_BOTH |=>
      $stable(cmd_q) && $stable(rng_q)
  ) else $error("partial command write was accepted");

  a_cmd_echo: assert property (
    frm_take |=>
      cmd_q == $past(frm)
  ) else $error("accepted frame not held in the command word");

  a_rsp_wr_ignored: assert property (
    bus_wr && idx_rsp |=>
      $stable(rsp_q)
  ) else $error("response word changed by a bus write");

  a_frame_wr_no_rsp: assert property ( // [RL1]
    frm_take && frm_is_wr |=>
      $stable(rsp_q)
  ) else $error("write frame changed the response");

  a_rsp_rsv_zero: assert property ( // [RL3]
    frm_rd |=>
      rsp_q[irc_pkg::FRM_RSV_BIT] == 1'b0
  ) else $error("reserved bit set in the response");

  a_rsp_adr_field: assert property ( // [RL10]
    frm_rd && frm_rng |=>
      rsp_q[irc_pkg::FRM_ADR_HI:irc_pkg::FRM_ADR_LO] == $past(frm_idx)
  ) else $error("response address field differs from target");

  a_rsp_unmapped: assert property (
    frm_rd && !frm_rng |=>
      rsp_q == 16'h0000
  ) else $error("read frame of unmapped target gave data");

  a_decode_5v: assert property ( // [RL4]
    rng_q[1][3:2] == irc_pkg::CODE_5V |=>
      o_grp_a_range[5] == irc_pkg::IRC_RNG_5V
  ) else $error("code 10 not decoded as 5 V");

  a_decode_11: assert property ( // [RL4]
    rng_q[0][5:4] == irc_pkg::CODE_10V_B |=>
      o_grp_a_range[2] == irc_pkg::IRC_RNG_10V
  ) else $error("code 11 not decoded as 10 V");

  a_layout_a_ch0: assert property ( // [RL5]
    1'b1 |=>
      o_grp_a_range_code[0] == $past(rng_q[0][1:0])
  ) else $error("group A channel 0 not at bits 1-0 of register 4");

  a_layout_a_ch7: assert property ( // [RL6]
    1'b1 |=>
      o_grp_a_range_code[7] == $past(rng_q[1][7:6])
  ) else $error("group A channel 7 not at bits 7-6 of register 5");

  a_layout_b_ch0: assert property ( // [RL9]
    1'b1 |=>
      o_grp_b_range_code[0] == $past(rng_q[2][1:0])
  ) else $error("group B channel 0 not at bits 1-0 of register 6");

  a_layout_b_ch3: assert property ( // [RL9]
    1'b1 |=>
      o_grp_b_range_code[3] == $past(rng_q[2][7:6])
  ) else $error("group B channel 3 not at bits 7-6 of register 6");

endmodule

// ### test/irc_host_model.sv
// Wishbone host model driving the range register bank
`timescale 1ns/1ps
module irc_host_model (
  input wire logic i_clk_sys,
  input wire irc_pkg::irc_wb_rsp_t i_rsp,
  output irc_pkg::irc_wb_req_t o_req
);
  initial o_req = '0;
  // One classic cycle; ok stays low on timeout
  task automatic xfer(input logic we, input logic [5:0] idx,
                      input logic [15:0] d, input logic [3:0] s,
                      output logic [31:0] q, output logic ok);
    int n;
    ok = 1'b0;
    q = '0;
    @(posedge i_clk_sys);
    o_req <= '{1'b1, 1'b1, we, s, {idx, 2'h0}, {16'h0000, d}};
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge i_clk_sys);
      if (i_rsp.ack === 1'b1) begin
        ok = 1'b1;
        q = i_rsp.dat;
      end
    end
    o_req <= '0;
  endtask
  // Command frame sent to the command word
  task automatic frame(input logic wr, input logic [5:0] idx,
                       input logic [7:0] c, output logic ok);
    logic [31:0] q;
    xfer(1'b1, irc_pkg::IDX_CMD, {wr, idx, 1'b0, c},
         4'hf, q, ok);
  endtask
endmodule

// ### test/tb_irc_range_regs.sv
// Self-checking bench of the range register bank
`timescale 1ns/1ps
module tb_irc_range_regs;
  logic i_clk_sys;
  logic i_rst_b;
  irc_pkg::irc_wb_req_t wb_req;
  irc_pkg::irc_wb_rsp_t wb_rsp;
  logic [7:0][1:0] a_code;
  logic [3:0][1:0] b_code;
  irc_pkg::irc_range_t [7:0] a_rng;
  irc_pkg::irc_range_t [3:0] b_rng;
  int fails;
  int check_count;
  int m[3];
  logic [31:0] q;
  logic ok;
  logic [5:0] idx;
  logic [15:0] d;

  irc_range_regs u_irc_range_regs (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_wb(wb_req), .o_wb(wb_rsp),
    .o_grp_a_range_code(a_code), .o_grp_b_range_code(b_code),
    .o_grp_a_range(a_rng), .o_grp_b_range(b_rng));
  irc_host_model u_irc_host_model (.i_clk_sys(i_clk_sys),
    .i_rsp(wb_rsp), .o_req(wb_req));

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic alive();
    if (ok !== 1'b1) begin
      fails++;
      test_done();
    end
  endtask

  task automatic bus(input logic we, input logic [5:0] i,
                     input logic [15:0] v);
    u_irc_host_model.xfer(we, i, v, 4'hf, q, ok);
    alive();
  endtask

  // Write with chosen byte lanes
  task automatic bus_sel(input logic [5:0] i, input logic [15:0] v,
                         input logic [3:0] s);
    u_irc_host_model.xfer(1'b1, i, v, s, q, ok);
    alive();
  endtask

  // Expected readback word from the model
  function automatic logic [31:0] word(input logic [5:0] i);
    word = '0;
    if (i >= 6'h04 && i <= 6'h06)
      word = {17'h0, i, 1'b0, 8'(m[int'(i) - 4])};
  endfunction

  function automatic irc_pkg::irc_range_t dec(input logic [1:0] c);
    dec = (c == 2'h1) ? irc_pkg::IRC_RNG_2P5V :
          (c == 2'h2) ? irc_pkg::IRC_RNG_5V : irc_pkg::IRC_RNG_10V;
  endfunction

  task automatic chk_out();
    logic [1:0] c;
    for (int ch = 0; ch < 12; ch++) begin
      c = 2'(m[ch / 4] >> (2 * (ch % 4)));
      cmp("code", c, ch < 8 ? a_code[ch] : b_code[ch%4]);
      cmp("range", dec(c), ch < 8 ? a_rng[ch] : b_rng[ch % 4]);
    end
  endtask

  initial begin
    i_rst_b = 1'b0;
    m = '{8'hff, 8'hff, 8'hff};
    fails = 0;
    check_count = 0;
    void'($urandom(32'hdadf));
    repeat (8) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    chk_out();
    for (int i = 4; i < 7; i++) begin
      bus(1'b0, 6'(i), 16'h0000);
      cmp("reset word", word(6'(i)), q);
    end
    // Random writes, direction and reserved bits included
    repeat (12) begin
      idx = 6'(4 + $urandom % 3);
      d = 16'($urandom);
      bus(1'b1, idx, d);
      m[idx - 6'h04] = d[7:0];
      bus(1'b0, idx, 16'h0000);
      cmp("direct word", word(idx), q);
      chk_out();
    end
    // Every code value on the channels, then a write with lane 0 off
    bus(1'b1, 6'h04, 16'hff39);
    m[0] = 8'h39;
    bus(1'b1, 6'h05, 16'h0039);
    m[1] = 8'h39;
    bus(1'b1, 6'h06, 16'h8039);
    m[2] = 8'h39;
    bus_sel(6'h05, 16'h0000, 4'he);
    chk_out();
    d = 16'($urandom);
    u_irc_host_model.frame(1'b1, 6'h05, d[7:0], ok);
    alive();
    m[1] = d[7:0];
    u_irc_host_model.frame(1'b1, 6'h3f, d[15:8], ok);
    alive();
    bus(1'b1, 6'h03, 16'hffff);
    for (int i = 3; i < 7; i++) begin
      u_irc_host_model.frame(1'b0, 6'(i), 8'h00, ok);
      alive();
      bus(1'b0, irc_pkg::IDX_RSP, 16'h0000);
      cmp("frame read", word(6'(i)), q);
    end
    bus_sel(irc_pkg::IDX_CMD, 16'h8bff, 4'h1);
    bus(1'b1, irc_pkg::IDX_RSP, 16'hffff);
    bus(1'b0, irc_pkg::IDX_RSP, 16'h0000);
    cmp("resp kept", word(6'h06), q);
    bus(1'b0, irc_pkg::IDX_CMD, 16'h0000);
    cmp("cmd echo", {16'h0000, 1'b0, 6'h06, 9'h000}, q);
    chk_out();
    // Reset in mid-run brings every code back to 11
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    m = '{8'hff, 8'hff, 8'hff};
    cmp("reset ack", 32'h0000_0000, {31'h0, wb_rsp.ack});
    cmp("reset dat", 32'h0000_0000, wb_rsp.dat);
    chk_out();
    for (int i = 4; i < 7; i++) begin
      bus(1'b0, 6'(i), 16'h0000);
      cmp("reset again", word(6'(i)), q);
    end
    test_done();
  end
endmodule
